/* hac_chain.v */
// Purpose: sample-rate audio chain, input select to output bridge
// Assumes: converters and radio logic share ref_clk_in
// Notes:   gains Q4.12 unsigned, biquad coefficients Q2.14 signed
//
// Functional notes
// - second path takes rear mic, telecoil or direct input by selector
// - single-mic setting uses the front path alone as main input
// - both inputs taken as 20-bit samples at 32 kHz or 16 kHz
// - matching biquad scales rear path to front path gain
// - calibrated group delay follows the matching biquad
// - adaptive and classifier modes adapt weights; fixed mode static
// - telecoil source uses its own calibrated trim gain
// - four cascaded shaping biquads follow directional stage
// - core: band analysis, compress/shape/denoise, then synthesis
// - compressor runs 1 linked channel for code 0, else 2 channels
// - shaping applies one gain each to the low and high bands
// - noise reduction attenuates each band independently
// - two tail biquads then the output gain stage
// - output stage: wideband gain then volume gain
// - two more tail biquads, peak clipper, output bridge
// - shaped, attenuated white noise added at one selectable point
// - radio audio and commands accepted only when receive enabled
`timescale 1ns/1ns
`include "hac_defs.vh"
`default_nettype none
module hac_chain #(
  parameter DLY_DEPTH = 8
) (
  input  wire        ref_clk_in,
  input  wire        rstn_in,
  input  wire [9:0]  addr_in,
  input  wire [31:0] wr_data_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [31:0] rd_data_out,
  input  wire [19:0] front_in,
  input  wire [19:0] rear_in,
  input  wire [19:0] tcoil_in,
  input  wire [19:0] dai_in,
  output reg         adc_strobe_out,
  output reg  [19:0] dac_data_out,
  output reg         dac_strobe_out,
  input  wire        rx_stream_valid_in,
  input  wire [19:0] rx_stream_in,
  input  wire        rx_cmd_valid_in,
  input  wire [7:0]  rx_cmd_in,
  output reg         rx_cmd_valid_out,
  output reg  [7:0]  rx_cmd_out
);
// ----------------------------------------
// helpers
// ----------------------------------------
function signed [19:0] sat20;
  input signed [39:0] v;
  begin
    sat20 = (v > 40'sh7_FFFF) ? 20'sh7_FFFF : ((v < -40'sh8_0000) ? 20'sh8_0000 : v[19:0]);
  end
endfunction
function signed [19:0] gmul;
  input signed [19:0] x;
  input [15:0] g;
  reg signed [39:0] p;
  begin
    p = x * $signed({1'b0, g});
    gmul = sat20(p >>> `HAC_GAIN_SH);
  end
endfunction
// ----------------------------------------
// registers
// ----------------------------------------
reg [12:0] ctrl_reg;
reg [31:0] trim_reg, gain_reg, shape_reg;
reg [18:0] dir_reg;
reg [19:0] clip_reg, out_reg;
reg [3:0]  noise_reg;
reg [26:0] comp_reg;
reg [23:0] nr_reg;
reg signed [15:0] coef_mem [0:44];
reg [7:0]  cmd_reg;
reg        clip_hit_reg;
reg signed [15:0] w_reg;
wire [1:0] src_sel    = ctrl_reg[1:0];
wire       single_mic = ctrl_reg[2];
wire       rate16     = ctrl_reg[3];
wire [1:0] dmode      = ctrl_reg[5:4];
wire       noise_post = ctrl_reg[6];
wire       rx_en      = ctrl_reg[7];
wire       noise_en   = ctrl_reg[8];
wire [2:0] nch_code   = ctrl_reg[11:9];
wire       use_stream = ctrl_reg[12];
wire       coef_hit   = (addr_in[9:8] == `HAC_COEF_PAGE) && (addr_in[7:2] < 6'd45);
integer i, j;
always @(posedge ref_clk_in or negedge rstn_in)
begin
  if (!rstn_in)
  begin
    ctrl_reg  <= 13'h0000;
    {trim_reg, gain_reg, shape_reg} <= {6{`HAC_UNITY_G}};
    dir_reg   <= {3'h0, `HAC_UNITY_G};
    clip_reg  <= `HAC_CLIP_RST;
    noise_reg <= 4'hF;
    comp_reg  <= {7'h00, `HAC_CLIP_RST};
    nr_reg    <= 24'h00_0000;
    for (i = 0; i < 45; i = i + 1)
      coef_mem[i] <= (i % 5 == 0) ? `HAC_UNITY_C : 16'h0000;
  end
  else if (wr_in)
  begin
    if (coef_hit)
      coef_mem[addr_in[7:2]] <= wr_data_in[15:0];
    case (addr_in)
      `HAC_A_CTRL:  ctrl_reg  <= wr_data_in[12:0];
      `HAC_A_TRIM:  trim_reg  <= wr_data_in;
      `HAC_A_DIR:   dir_reg   <= wr_data_in[18:0];
      `HAC_A_GAIN:  gain_reg  <= wr_data_in;
      `HAC_A_CLIP:  clip_reg  <= wr_data_in[19:0];
      `HAC_A_NOISE: noise_reg <= wr_data_in[3:0];
      `HAC_A_COMP:  comp_reg  <= wr_data_in[26:0];
      `HAC_A_SHAPE: shape_reg <= wr_data_in;
      `HAC_A_NR:    nr_reg    <= wr_data_in[23:0];
      default:      ;
    endcase
  end
end
// read data stands the cycle after each cycle with rd_in high, zero otherwise
always @(posedge ref_clk_in or negedge rstn_in)
begin
  if (!rstn_in)
    rd_data_out <= 32'h0000_0000;
  else if (!rd_in)
    rd_data_out <= 32'h0000_0000;
  else if (coef_hit)
    rd_data_out <= {16'h0000, coef_mem[addr_in[7:2]]};
  else
    case (addr_in)
      `HAC_A_CTRL:  rd_data_out <= {19'h0_0000, ctrl_reg};
      `HAC_A_TRIM:  rd_data_out <= trim_reg;
      `HAC_A_DIR:   rd_data_out <= {13'h0000, dir_reg};
      `HAC_A_GAIN:  rd_data_out <= gain_reg;
      `HAC_A_CLIP:  rd_data_out <= {12'h000, clip_reg};
      `HAC_A_NOISE: rd_data_out <= {28'h000_0000, noise_reg};
      `HAC_A_COMP:  rd_data_out <= {5'h00, comp_reg};
      `HAC_A_SHAPE: rd_data_out <= shape_reg;
      `HAC_A_NR:    rd_data_out <= {8'h00, nr_reg};
      `HAC_A_STAT:  rd_data_out <= {7'h00, clip_hit_reg, cmd_reg, w_reg};
      `HAC_A_OUT:   rd_data_out <= {12'h000, out_reg};
      default:      rd_data_out <= 32'h0000_0000;
    endcase
end
// ----------------------------------------
// sample strobe
// ----------------------------------------
reg [10:0] div_reg;
localparam integer DIV_HI_M1 = `HAC_DIV_HI - 1, DIV_LO_M1 = `HAC_DIV_LO - 1;
wire [10:0] div_end = rate16 ? DIV_LO_M1[10:0] : DIV_HI_M1[10:0];
wire stb = adc_strobe_out;
always @(posedge ref_clk_in or negedge rstn_in)
begin
  if (!rstn_in)
    {div_reg, adc_strobe_out} <= 12'h000;
  else
  begin
    adc_strobe_out <= (div_reg >= div_end);
    div_reg        <= (div_reg >= div_end) ? 11'h000 : div_reg + 11'h001;
  end
end
// ----------------------------------------
// input selection and directional stage
// ----------------------------------------
reg signed [19:0] sec_raw, main_reg, sec_reg, strm_reg, dir_out;
reg signed [19:0] dly [0:DLY_DEPTH-1];
wire signed [19:0] bq_in  [0:8];
wire signed [19:0] bq_out [0:8];
always @*
begin
  case (src_sel)
    `HAC_SRC_TCOIL: sec_raw = tcoil_in;
    `HAC_SRC_DAI:   sec_raw = dai_in;
    default:        sec_raw = rear_in;
  endcase
end
wire [15:0] sec_trim = (src_sel == `HAC_SRC_TCOIL) ? trim_reg[31:16] : trim_reg[15:0];
wire signed [19:0] rear_d = dly[dir_reg[18:16]];
wire signed [19:0] comb   = sat20(main_reg - gmul(rear_d, w_reg[15:0]));
wire adaptive = (dmode == `HAC_DM_ADAPT) || (dmode == `HAC_DM_CLASS);
always @(posedge ref_clk_in or negedge rstn_in)
begin
  if (!rstn_in)
  begin
    {main_reg, sec_reg, strm_reg, dir_out} <= 80'h0000_0000_0000_0000_0000;
    {w_reg, cmd_reg, rx_cmd_out, rx_cmd_valid_out} <= 33'h0_0000_0000;
    for (j = 0; j < DLY_DEPTH; j = j + 1)
      dly[j] <= 20'h0_0000;
  end
  else
  begin
    rx_cmd_valid_out <= rx_en && rx_cmd_valid_in;
    if (rx_en && rx_cmd_valid_in)
    begin
      rx_cmd_out <= rx_cmd_in;
      cmd_reg    <= rx_cmd_in;
    end
    if (rx_en && rx_stream_valid_in)
      strm_reg <= rx_stream_in;
    if (!adaptive)
      w_reg <= dir_reg[15:0];
    if (stb)
    begin
      main_reg <= (use_stream && rx_en) ? strm_reg : front_in;
      sec_reg  <= gmul(sec_raw, sec_trim);
      dly[0]   <= bq_out[0];
      for (j = 1; j < DLY_DEPTH; j = j + 1)
        dly[j] <= dly[j-1];
      if (single_mic || dmode == `HAC_DM_OMNI)
        dir_out <= main_reg;
      else
        dir_out <= comb;
      // sign-sign update steers the null toward least output power
      if (adaptive && !single_mic)
      begin
        if ((comb[19] ^ rear_d[19]) && w_reg > 16'sh0000)
          w_reg <= w_reg - `HAC_W_STEP;
        else if (!(comb[19] ^ rear_d[19]) && w_reg < 16'sh1000)
          w_reg <= w_reg + `HAC_W_STEP;
      end
    end
  end
end
// ----------------------------------------
// biquad sections: 0 match, 1-4 shaping, 5-8 tail
// ----------------------------------------
reg signed [19:0] core_out, vol_out;
assign bq_in[0] = sec_reg;
assign bq_in[1] = dir_out;
assign bq_in[5] = core_out;
assign bq_in[7] = vol_out;
genvar k;
generate
  for (k = 0; k < 9; k = k + 1)
  begin : g_bq
    reg signed [19:0] x1, x2, y1, y2;
    wire signed [39:0] acc = coef_mem[k*5] * bq_in[k] + coef_mem[k*5+1] * x1
                           + coef_mem[k*5+2] * x2 - coef_mem[k*5+3] * y1
                           - coef_mem[k*5+4] * y2;
    if (k == 2 || k == 3 || k == 4 || k == 6 || k == 8)
    begin : g_link
      assign bq_in[k] = bq_out[k-1];
    end
    assign bq_out[k] = y1;
    always @(posedge ref_clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
        {x1, x2, y1, y2} <= 80'h0000_0000_0000_0000_0000;
      else if (stb)
      begin
        x1 <= bq_in[k];
        x2 <= x1;
        y1 <= sat20(acc >>> `HAC_COEF_SH);
        y2 <= y1;
      end
    end
  end
endgenerate
// ----------------------------------------
// channel core
// ----------------------------------------
// two-band split keeps area small; band count is a limitation
reg signed [19:0] lp_reg, env_lo, env_hi;
wire signed [19:0] band_lo = lp_reg;
wire signed [19:0] band_hi = sat20(bq_out[4] - lp_reg);
wire signed [19:0] abs_lo  = band_lo[19] ? -band_lo : band_lo;
wire signed [19:0] abs_hi  = band_hi[19] ? -band_hi : band_hi;
wire one_ch  = (nch_code == 3'h0);
wire [19:0] thr = comp_reg[19:0];
wire [3:0]  rsh = comp_reg[23:20];
wire signed [19:0] e_lo = one_ch ? sat20(env_lo + env_hi) : env_lo;
wire signed [19:0] e_hi = one_ch ? sat20(env_lo + env_hi) : env_hi;
wire signed [19:0] c_lo = (e_lo > $signed(thr)) ? band_lo >>> rsh : band_lo;
wire signed [19:0] c_hi = (e_hi > $signed(thr)) ? band_hi >>> rsh : band_hi;
wire signed [19:0] s_lo = gmul(c_lo, shape_reg[15:0]);
wire signed [19:0] s_hi = gmul(c_hi, shape_reg[31:16]);
wire signed [19:0] n_lo = (env_lo < $signed(nr_reg[19:0])) ? s_lo >>> nr_reg[23:20] : s_lo;
wire signed [19:0] n_hi = (env_hi < $signed(nr_reg[19:0])) ? s_hi >>> nr_reg[23:20] : s_hi;
always @(posedge ref_clk_in or negedge rstn_in)
begin
  if (!rstn_in)
    {lp_reg, env_lo, env_hi, core_out} <= 80'h0000_0000_0000_0000_0000;
  else if (stb)
  begin
    lp_reg   <= sat20(lp_reg + ((bq_out[4] - lp_reg) >>> 3));
    env_lo   <= sat20(env_lo + ((abs_lo - env_lo) >>> 5));
    env_hi   <= sat20(env_hi + ((abs_hi - env_hi) >>> 5));
    core_out <= sat20(n_lo + n_hi);
  end
end
// ----------------------------------------
// noise, output gain, clipper
// ----------------------------------------
reg [19:0] lfsr_reg;
reg signed [19:0] nlp_reg;
wire signed [19:0] noise = noise_en ? (nlp_reg >>> noise_reg) : 20'sh0_0000;
wire signed [19:0] wb    = gmul(bq_out[6], gain_reg[15:0]);
wire signed [19:0] wbn   = noise_post ? wb : sat20(wb + noise);
wire signed [19:0] pre   = noise_post ? sat20(bq_out[8] + noise) : bq_out[8];
// a limit word above full scale would read as negative; hold it at full scale
wire signed [19:0] lim   = clip_reg[19] ? `HAC_CLIP_RST : clip_reg;
wire hi_clip = pre > lim;
wire lo_clip = pre < -lim;
wire signed [19:0] clipped = hi_clip ? lim : (lo_clip ? -lim : pre);
always @(posedge ref_clk_in or negedge rstn_in)
begin
  if (!rstn_in)
  begin
    lfsr_reg <= `HAC_LFSR_INIT;
    {nlp_reg, vol_out, out_reg, dac_data_out} <= 80'h0000_0000_0000_0000_0000;
    {clip_hit_reg, dac_strobe_out} <= 2'h0;
  end
  else
  begin
    dac_strobe_out <= stb;
    if (stb)
    begin
      lfsr_reg <= {lfsr_reg[18:0], lfsr_reg[19] ^ lfsr_reg[16]};
      nlp_reg  <= sat20(nlp_reg + (($signed(lfsr_reg) - nlp_reg) >>> 2));
      vol_out  <= gmul(wbn, gain_reg[31:16]);
      clip_hit_reg <= hi_clip || lo_clip;
      dac_data_out <= clipped;
      out_reg      <= clipped;
    end
  end
end
endmodule
`default_nettype wire

/* hac_chain_sva.sv */
// Purpose: port timing checker for hac_chain
// Assumes: one clock, async active-low reset
// Notes:   bound to every hac_chain instance
`timescale 1ns/1ns
`default_nettype none
`include "hac_defs.vh"
module hac_chain_sva (
  input wire logic        ref_clk_in,
  input wire logic        rstn_in,
  input wire logic [9:0]  addr_in,
  input wire logic        wr_in,
  input wire logic        adc_strobe_out,
  input wire logic        dac_strobe_out,
  input wire logic [19:0] dac_data_out,
  input wire logic        rx_cmd_valid_in,
  input wire logic [7:0]  rx_cmd_in,
  input wire logic        rx_cmd_valid_out,
  input wire logic [7:0]  rx_cmd_out
);
  logic [11:0] gap_reg;
  logic        seen_reg;
  // ----------------------------------------
  // strobe gap, forgotten on control writes since the rate may change
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      gap_reg  <= 12'h000;
      seen_reg <= 1'b0;
    end
    else
    begin
      gap_reg  <= adc_strobe_out ? 12'h000 : gap_reg + 12'h001;
      seen_reg <= (wr_in && addr_in == `HAC_A_CTRL) ? 1'b0 : (seen_reg | adc_strobe_out);
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  a_dac_follows_adc: assert property (adc_strobe_out |=> dac_strobe_out)
    else $error("dac strobe missing after adc strobe");
  a_dac_has_cause: assert property (dac_strobe_out |-> $past(adc_strobe_out))
    else $error("dac strobe without adc strobe");
  a_dac_data_held: assert property (!dac_strobe_out |-> $stable(dac_data_out))
    else $error("dac data moved inside a sample period");
  a_adc_pulse_gap: assert property (adc_strobe_out |=> !adc_strobe_out [*8])
    else $error("adc strobes too close");
  a_period_exact: assert property (adc_strobe_out && seen_reg |-> gap_reg == 12'h30C || gap_reg == 12'h619)
    else $error("sample period not 781 or 1562 cycles");
  a_clip_no_wrap: assert property (dac_strobe_out |-> dac_data_out != 20'h8_0000)
    else $error("output reached the most negative code");
  a_cmd_has_cause: assert property (rx_cmd_valid_out |-> $past(rx_cmd_valid_in))
    else $error("command out without command in");
  a_cmd_value: assert property (rx_cmd_valid_out |-> rx_cmd_out == $past(rx_cmd_in))
    else $error("command out differs from command in");
  a_cmd_held: assert property (!rx_cmd_valid_out |-> $stable(rx_cmd_out))
    else $error("last command changed without a new one");
endmodule
bind hac_chain hac_chain_sva chk_u (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wr_in(wr_in),
  .adc_strobe_out(adc_strobe_out), .dac_strobe_out(dac_strobe_out), .dac_data_out(dac_data_out),
  .rx_cmd_valid_in(rx_cmd_valid_in), .rx_cmd_in(rx_cmd_in), .rx_cmd_valid_out(rx_cmd_valid_out),
  .rx_cmd_out(rx_cmd_out));
`default_nettype wire

/* hac_chain_test.sv */
// Purpose: self-checking bench for hac_chain
// Assumes: unity gains and pass-through biquads out of reset
// Notes:   waits of 14 samples cover the 13-sample chain latency, 16 with the second path
`timescale 1ns/1ns
`default_nettype none
`include "hac_defs.vh"
module hac_chain_test;
  logic ref_clk_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [9:0]  addr_in = 10'h000;
  logic [31:0] wr_data_in = 32'h0000_0000, rd_data_out, rv;
  logic [19:0] front_in, rear_in, tcoil_in, dai_in, dac_data_out, last_dac;
  logic [19:0] fl = 20'h0_1234, sl = 20'h0_ABCD, rx_stream_in = 20'h0_0321;
  logic        adc_strobe_out, dac_strobe_out, rx_cmd_valid_out;
  logic        rx_stream_valid_in = 1'b0, rx_cmd_valid_in = 1'b0;
  logic [7:0]  rx_cmd_in = 8'h00, rx_cmd_out;
  logic [15:0] nsmp;
  logic [11:0] period;
  logic [9:0]  ra [11] = '{10'h000, 10'h004, 10'h008, 10'h00C, 10'h010, 10'h014, 10'h018, 10'h01C, 10'h020,
                           10'h100, 10'h3FC};
  logic [31:0] rvals [11] = '{32'h0000_0000, 32'h1000_1000, 32'h0000_1000, 32'h1000_1000, 32'h0007_FFFF,
                              32'h0000_000F, 32'h0007_FFFF, 32'h1000_1000, 32'h0000_0000, 32'h0000_4000,
                              32'h0000_0000};
  int miscompares = 0, checks_done = 0, cyc = 0;
  hac_chain dut_u (.ref_clk_in, .rstn_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out, .front_in,
    .rear_in, .tcoil_in, .dai_in, .adc_strobe_out, .dac_data_out, .dac_strobe_out, .rx_stream_valid_in,
    .rx_stream_in, .rx_cmd_valid_in, .rx_cmd_in, .rx_cmd_valid_out, .rx_cmd_out);
  hac_conv_model conv_u (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .adc_strobe_in(adc_strobe_out),
    .dac_strobe_in(dac_strobe_out), .dac_data_in(dac_data_out), .front_lvl_in(fl), .sec_lvl_in(sl),
    .front_out(front_in), .rear_out(rear_in), .tcoil_out(tcoil_in), .dai_out(dai_in),
    .last_dac_out(last_dac), .nsmp_out(nsmp), .period_out(period));
  always #20 ref_clk_in = ~ref_clk_in;
  // ----------------------------------------
  // bus access, comparison and verdict
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_in      <= 1'b1;
    @(posedge ref_clk_in);
    wr_in      <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    rd_in   <= 1'b0;
    #1 rv = rd_data_out;
  endtask
  task automatic settle(input logic [15:0] n);
    logic [15:0] t;
    t = nsmp;
    wait (nsmp == t + n);
    #1;
  endtask
  task automatic cmd(input logic [7:0] c, input logic v);
    @(posedge ref_clk_in);
    rx_cmd_valid_in <= 1'b1;
    rx_cmd_in       <= c;
    @(posedge ref_clk_in);
    rx_cmd_valid_in <= 1'b0;
    #1 chk("cmd valid", {31'h0, v}, {31'h0, rx_cmd_valid_out});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      miscompares++;
      end_sim();
    end
  end
  initial
  begin
    repeat (6) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      rd(ra[i]);
      chk("reset value", rvals[i], rv);
    end
    $display("test reset_values done");
    for (int s = 0; s < 3; s++)
    begin
      wr(`HAC_A_CTRL, 32'h0000_0004 | s);
      @(posedge ref_clk_in) sl <= sl + 20'h0_1111;
      settle(14);
      chk("single mic out", 32'h0000_1234, {12'h0, last_dac});
    end
    rd(`HAC_A_OUT);
    chk("out register", 32'h0000_1234, rv);
    wr(`HAC_A_GAIN, 32'h1000_2000);
    settle(14);
    chk("wideband gain", 32'h0000_2468, {12'h0, last_dac});
    $display("test path_gain done");
    wr(`HAC_A_CLIP, 32'h0000_1000);
    settle(14);
    chk("clip positive", 32'h0000_1000, {12'h0, last_dac});
    rd(`HAC_A_STAT);
    chk("clip flag", 32'h0000_0001, {31'h0, rv[24]});
    @(posedge ref_clk_in) fl <= 20'hF_0000;
    settle(14);
    chk("clip negative", 32'h000F_F000, {12'h0, last_dac});
    $display("test clipper done");
    wr(`HAC_A_CTRL, 32'h0000_000C);
    settle(3);
    chk("period 16k", 32'h0000_061A, {20'h0, period});
    wr(`HAC_A_CTRL, 32'h0000_0004);
    settle(3);
    chk("period 32k", 32'h0000_030D, {20'h0, period});
    $display("test rate done");
    cmd(8'hA5, 1'b0);
    chk("cmd ignored", 32'h0000_0000, {24'h0, rx_cmd_out});
    wr(`HAC_A_CTRL, 32'h0000_0084);
    cmd(8'h3C, 1'b1);
    chk("cmd taken", 32'h0000_003C, {24'h0, rx_cmd_out});
    rd(`HAC_A_STAT);
    chk("status cmd", 32'h0000_003C, {24'h0, rv[23:16]});
    @(posedge ref_clk_in) rx_stream_valid_in <= 1'b1;
    sl <= 20'h0_0100;
    wr(`HAC_A_TRIM, 32'h0800_1000);
    wr(`HAC_A_CTRL, 32'h0000_1091);
    settle(16);
    chk("stream minus telecoil", 32'h0000_0444, {12'h0, last_dac});
    $display("test radio done");
    end_sim();
  end
endmodule
`default_nettype wire

/* hac_conv_model.sv */
// Purpose: converter model feeding and watching hac_chain
// Assumes: samples are taken at the adc strobe edge only
// Notes:   inputs are scrambled for one cycle after each strobe
`timescale 1ns/1ns
`default_nettype none
module hac_conv_model (
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        adc_strobe_in,
  input  wire logic        dac_strobe_in,
  input  wire logic [19:0] dac_data_in,
  input  wire logic [19:0] front_lvl_in,
  input  wire logic [19:0] sec_lvl_in,
  output logic      [19:0] front_out,
  output logic      [19:0] rear_out,
  output logic      [19:0] tcoil_out,
  output logic      [19:0] dai_out,
  output logic      [19:0] last_dac_out,
  output logic      [15:0] nsmp_out,
  output logic      [11:0] period_out
);
  logic [11:0] cnt_reg;
  logic [19:0] s;
  // ----------------------------------------
  // a late sampler sees the inverse, not a held value
  // ----------------------------------------
  assign s = adc_strobe_in ? 20'hF_FFFF : 20'h0_0000;
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      {front_out, rear_out, tcoil_out, dai_out, last_dac_out} <= '0;
      {nsmp_out, period_out, cnt_reg} <= '0;
    end
    else
    begin
      front_out <= front_lvl_in ^ s;
      rear_out  <= sec_lvl_in ^ s;
      tcoil_out <= sec_lvl_in ^ 20'h0_00FF ^ s;
      dai_out   <= sec_lvl_in ^ 20'h0_FF00 ^ s;
      cnt_reg   <= adc_strobe_in ? 12'h000 : cnt_reg + 12'h001;
      if (adc_strobe_in)
        period_out <= cnt_reg + 12'h001;
      if (dac_strobe_in)
      begin
        last_dac_out <= dac_data_in;
        nsmp_out     <= nsmp_out + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* hac_defs.vh */
// Purpose: constants for the hearing-aid audio chain
// Assumes: 25 MHz reference clock, word-aligned register port
// Notes:   offsets are byte addresses
`ifndef HAC_DEFS_VH
`define HAC_DEFS_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define HAC_CLK_HZ    25000000
`define HAC_FS_HI_HZ  32000
`define HAC_FS_LO_HZ  16000
`define HAC_DIV_HI    (`HAC_CLK_HZ / `HAC_FS_HI_HZ)
`define HAC_DIV_LO    (`HAC_CLK_HZ / `HAC_FS_LO_HZ)
// ----------------------------------------
// register offsets
// ----------------------------------------
`define HAC_A_CTRL    10'h000
`define HAC_A_TRIM    10'h004
`define HAC_A_DIR     10'h008
`define HAC_A_GAIN    10'h00C
`define HAC_A_CLIP    10'h010
`define HAC_A_NOISE   10'h014
`define HAC_A_COMP    10'h018
`define HAC_A_SHAPE   10'h01C
`define HAC_A_NR      10'h020
`define HAC_A_STAT    10'h024
`define HAC_A_OUT     10'h028
`define HAC_COEF_PAGE 2'h1
// ----------------------------------------
// field values and reset values
// ----------------------------------------
`define HAC_SRC_REAR  2'h0
`define HAC_SRC_TCOIL 2'h1
`define HAC_SRC_DAI   2'h2
`define HAC_DM_OMNI   2'h0
`define HAC_DM_FIXED  2'h1
`define HAC_DM_ADAPT  2'h2
`define HAC_DM_CLASS  2'h3
`define HAC_UNITY_G   16'h1000
`define HAC_UNITY_C   16'h4000
`define HAC_GAIN_SH   12
`define HAC_COEF_SH   14
`define HAC_LFSR_INIT 20'h0_0001
`define HAC_CLIP_RST  20'h7_FFFF
`define HAC_W_STEP    16'h0004
`endif
